// ### verilog/rbg_pkg.sv
package rbg_pkg;

  // Pin counts for the two package variants
  localparam int GPIO_NUM       = 14;
  localparam int GPIO_NUM_SMALL = 11;

  typedef logic [GPIO_NUM-1:0] rbg_gpio_t;

  localparam rbg_gpio_t PIN_MASK_LARGE = 14'h3FFF;
  localparam rbg_gpio_t PIN_MASK_SMALL = 14'h07FF;

  // Register offsets, byte addresses
  localparam logic [7:0] REG_DIR    = 8'h00;
  localparam logic [7:0] REG_OUT    = 8'h04;
  localparam logic [7:0] REG_IN     = 8'h08;
  localparam logic [7:0] REG_EVENT  = 8'h0C;
  localparam logic [7:0] REG_MASK   = 8'h10;
  localparam logic [7:0] REG_STRAP  = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_CTRL   = 8'h1C;

  // Field positions
  localparam int CTRL_CFG_DONE_BIT = 0;
  localparam int STRAP_CLK_LO      = 0;
  localparam int STRAP_BOOT_BIT    = 2;
  localparam int STAT_ANALOG_BIT   = 3;
  localparam int STAT_TIMEOUT_BIT  = 4;
  localparam int STAT_EXT_BIT      = 5;
  localparam int STAT_SMALL_BIT    = 6;

  // Reset values
  localparam rbg_gpio_t GPIO_RST = 14'h0000;

  // Timing at the 40 ns clock
  localparam int CLK_PERIOD_NS     = 40;
  localparam int T_RST_MIN_NS      = 100;
  localparam int T_RST_DIG_MAX_NS  = 1000;
  localparam int T_RST_ANA_NS      = 10000;
  localparam int T_PLL_START_MS    = 3;
  localparam int T_BOOT_DELAY_MS   = 3;
  localparam int T_BOOT_LIMIT_S    = 1;

  localparam int RST_MIN_CYC_I =
    (T_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_DIG_MAX_CYC_I = T_RST_DIG_MAX_NS / CLK_PERIOD_NS;
  localparam int RST_ANA_CYC_I =
    (T_RST_ANA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [8:0] RST_MIN_CYC     = 9'(RST_MIN_CYC_I);
  localparam logic [8:0] RST_DIG_MAX_CYC = 9'(RST_DIG_MAX_CYC_I);
  localparam logic [8:0] RST_ANA_CYC     = 9'(RST_ANA_CYC_I);
  localparam logic [8:0] LOW_CNT_SAT     = 9'(RST_ANA_CYC_I + 1);

  localparam int PLL_WAIT_CYC_DFLT =
    (T_PLL_START_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BOOT_DLY_CYC_DFLT =
    (T_BOOT_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BOOT_LIMIT_CYC_DFLT =
    (T_BOOT_LIMIT_S * 1000000000) / CLK_PERIOD_NS;

  localparam logic [24:0] TIMER_MAX = 25'h1FF_FFFF;

  typedef enum logic [2:0] {
    ST_SENSE    = 3'b000,
    ST_BOOT_DLY = 3'b001,
    ST_BOOT     = 3'b010,
    ST_READY    = 3'b011,
    ST_HELD     = 3'b100,
    ST_PLL_WAIT = 3'b101
  } rbg_state_e;

  typedef struct packed {
    logic       small_pkg;
    logic       ext_supply;
    logic       auto_boot;
    logic [1:0] clk_sel;
  } rbg_boot_opt_s;

  localparam rbg_boot_opt_s BOOT_OPT_RST = 5'h00;

endpackage : rbg_pkg

// ### verilog/rbg_ctrl.sv
// Notes on behaviour
// - 14 pins on the large package, 11 on the small one.
// - Each pin is an input or an output on its own.
// - Each pin has its own maskable event; all pins share one host interrupt.
// - Input pins are sampled and latched into a readable register.
// - A level change on an input pin raises an event.
// - After any reset all pins are inputs; levels go to the strap register.
// - The strap register selects clock source and boot source.
// - After the configuration load, directions follow software settings.
// - A low pulse of 100 ns or more resets all state and registers.
// - Low beyond 10 us also cuts the PLL and core supply control.
// - Release after analog reset restores supply and PLL, waits 3 ms.
// - Release of either reset type restarts the boot.
// - After analog reset boot waits until clocks are back.
// - Strap sampling follows both digital and analog resets.
// - Straps are sensed first; boot starts 3 ms later.
// - Auto boot must finish within 1 s, else a timeout flag.
// - Supply select strap high: external supply; low: internal regulator.
// - External mode: control output high enables, low disables supply.
// - Reset low beyond 10 us forces the supply control low.
`timescale 1ns/1ps
module rbg_ctrl
  import rbg_pkg::*;
#(
  parameter int PLL_WAIT_CYC   = PLL_WAIT_CYC_DFLT,
  parameter int BOOT_DLY_CYC   = BOOT_DLY_CYC_DFLT,
  parameter int BOOT_LIMIT_CYC = BOOT_LIMIT_CYC_DFLT
)(
  input  wire logic          CLOCK_I,
  input  wire logic          RESET_N_I,
  input  wire logic          PIN_RESET_N_I,
  input  wire logic          SUPPLY_SOURCE_SELECT_I,
  input  wire logic          PACKAGE_SMALL_I,
  input  wire rbg_gpio_t     GPIO_I,
  output logic [13:0]        GPIO_O,
  output logic [13:0]        GPIO_OE_O,
  input  wire logic [7:0]    ADDR_I,
  input  wire logic [31:0]   WDATA_I,
  input  wire logic          WR_I,
  input  wire logic          RD_I,
  output logic [31:0]        RDATA_O,
  output logic               CORE_SUPPLY_CONTROL_O,
  output logic               REGULATOR_INTERNAL_O,
  output logic               PLL_ENABLE_O,
  output logic               CORE_RESET_N_O,
  output logic               BOOT_START_O,
  output logic               BOOT_DONE_O,
  output logic               BOOT_TIMEOUT_O,
  output rbg_boot_opt_s      BOOT_OPT_O,
  output logic               GPIO_IRQ_O,
  output logic [13:0]        GPIO_EVENT_O
);

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESET_N_I);

  rbg_state_e    state;
  rbg_state_e    next_state;
  logic [8:0]    low_cnt;
  logic [24:0]   timer;
  logic          held_now;
  logic          ana_hit;
  logic          ana_flag;
  logic          ana_seen;
  logic          pwr_on;
  logic          soft_clr;
  logic          cfg_done;
  logic          timeout;
  rbg_boot_opt_s boot_opt;
  rbg_gpio_t     strap;
  rbg_gpio_t     dir;
  rbg_gpio_t     out_val;
  rbg_gpio_t     gpio_in;
  rbg_gpio_t     evt;
  rbg_gpio_t     mask;
  rbg_gpio_t     pin_mask;
  rbg_gpio_t     edge_hit;
  rbg_gpio_t     evt_clr;
  logic [31:0]   next_rdata;

  // Length of the current low pulse on the reset pin, saturating
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || PIN_RESET_N_I) begin
      low_cnt <= 9'h000;
    end else if (low_cnt != LOW_CNT_SAT) begin
      low_cnt <= low_cnt + 9'h001;
    end
  end

  // Pulses shorter than the minimum are glitches and are ignored
  assign held_now = !PIN_RESET_N_I && (low_cnt >= RST_MIN_CYC - 9'h001);
  assign ana_hit  = !PIN_RESET_N_I && (low_cnt >= RST_ANA_CYC);
  assign soft_clr = !RESET_N_I || (state == ST_HELD);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_SENSE: begin
        next_state = ST_BOOT_DLY;
      end
      ST_BOOT_DLY: begin
        if (timer >= 25'(BOOT_DLY_CYC - 1)) begin
          next_state = ST_BOOT;
        end
      end
      ST_BOOT: begin
        if (cfg_done) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        next_state = ST_READY;
      end
      ST_HELD: begin
        if (PIN_RESET_N_I) begin
          next_state = ana_flag ? ST_PLL_WAIT : ST_SENSE;
        end
      end
      ST_PLL_WAIT: begin
        if (timer >= 25'(PLL_WAIT_CYC - 1)) begin
          next_state = ST_SENSE;
        end
      end
      default: begin
        next_state = ST_SENSE;
      end
    endcase
    if (held_now && state != ST_HELD) begin
      next_state = ST_HELD;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      state <= ST_SENSE;
    end else begin
      state <= next_state;
    end
  end

  // One timer serves each timed state; it restarts on every change
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || next_state != state) begin
      timer <= 25'h000_0000;
    end else if (timer != TIMER_MAX) begin
      timer <= timer + 25'h000_0001;
    end
  end

  // Analog reset bookkeeping; kept outside the digital clear
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ana_flag <= 1'b0;
    end else if (ana_hit) begin
      ana_flag <= 1'b1;
    end else if (state == ST_PLL_WAIT && next_state != ST_PLL_WAIT) begin
      ana_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ana_seen <= 1'b0;
    end else if (state == ST_HELD && PIN_RESET_N_I) begin
      ana_seen <= ana_flag;
    end
  end

  // Supply control and PLL drop together and return at release
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      pwr_on <= 1'b1;
    end else if (ana_hit) begin
      pwr_on <= 1'b0;
    end else if (PIN_RESET_N_I) begin
      pwr_on <= 1'b1;
    end
  end

  // Same polarity in both modes: high enables regulator or FET
  assign CORE_SUPPLY_CONTROL_O = pwr_on;
  assign PLL_ENABLE_O          = pwr_on;
  assign REGULATOR_INTERNAL_O  = !boot_opt.ext_supply;

  // Straps are caught only in the sensing state, pins all inputs then
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      strap    <= GPIO_RST;
      boot_opt <= BOOT_OPT_RST;
    end else if (state == ST_SENSE) begin
      strap <= GPIO_I & (PACKAGE_SMALL_I ? PIN_MASK_SMALL
                                         : PIN_MASK_LARGE);
      boot_opt.small_pkg  <= PACKAGE_SMALL_I;
      boot_opt.ext_supply <= SUPPLY_SOURCE_SELECT_I;
      boot_opt.auto_boot  <= GPIO_I[STRAP_BOOT_BIT];
      boot_opt.clk_sel    <= GPIO_I[STRAP_CLK_LO +: 2];
    end
  end

  assign BOOT_OPT_O = boot_opt;
  assign pin_mask   = boot_opt.small_pkg ? PIN_MASK_SMALL
                                         : PIN_MASK_LARGE;

  always_ff @(posedge CLOCK_I) begin
    if (soft_clr) begin
      BOOT_START_O <= 1'b0;
    end else begin
      BOOT_START_O <= (state == ST_BOOT_DLY) && (next_state == ST_BOOT);
    end
  end

  assign BOOT_DONE_O = (state == ST_READY);

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      CORE_RESET_N_O <= 1'b0;
    end else begin
      CORE_RESET_N_O <= (next_state != ST_HELD);
    end
  end

  // Only auto boot has a bounded load time; host boot may take longer
  always_ff @(posedge CLOCK_I) begin
    if (soft_clr) begin
      timeout <= 1'b0;
    end else if (state == ST_BOOT && boot_opt.auto_boot &&
                 timer >= 25'(BOOT_LIMIT_CYC - 1)) begin
      timeout <= 1'b1;
    end
  end

  assign BOOT_TIMEOUT_O = timeout;
  assign cfg_done = WR_I && (ADDR_I == REG_CTRL) &&
                    WDATA_I[CTRL_CFG_DONE_BIT] && (state == ST_BOOT);

  // Software registers, all cleared by any qualified reset
  always_ff @(posedge CLOCK_I) begin
    if (soft_clr) begin
      dir     <= GPIO_RST;
      out_val <= GPIO_RST;
      mask    <= GPIO_RST;
    end else if (WR_I) begin
      if (ADDR_I == REG_DIR) begin
        dir <= WDATA_I[13:0];
      end
      if (ADDR_I == REG_OUT) begin
        out_val <= WDATA_I[13:0];
      end
      if (ADDR_I == REG_MASK) begin
        mask <= WDATA_I[13:0];
      end
    end
  end

  // Pins drive only once the configuration is in
  always_ff @(posedge CLOCK_I) begin
    if (soft_clr) begin
      GPIO_OE_O <= GPIO_RST;
      GPIO_O    <= GPIO_RST;
    end else begin
      GPIO_OE_O <= (state == ST_READY) ? (dir & pin_mask)
                                       : GPIO_RST;
      GPIO_O    <= out_val & pin_mask;
    end
  end

  // Output pins keep their last input sample
  always_ff @(posedge CLOCK_I) begin
    if (soft_clr) begin
      gpio_in <= GPIO_RST;
    end else begin
      gpio_in <= ((gpio_in & dir) | (GPIO_I & ~dir)) & pin_mask;
    end
  end

  // Edges counted only when running, so strap levels raise nothing
  assign edge_hit = (state == ST_READY) ?
                    ((gpio_in ^ GPIO_I) & ~dir & pin_mask) : GPIO_RST;
  assign evt_clr  = (WR_I && ADDR_I == REG_EVENT) ? WDATA_I[13:0]
                                                  : GPIO_RST;

  // Write one to clear; a new edge in the same cycle wins
  always_ff @(posedge CLOCK_I) begin
    if (soft_clr) begin
      evt          <= GPIO_RST;
      GPIO_EVENT_O <= GPIO_RST;
    end else begin
      evt          <= (evt & ~evt_clr) | edge_hit;
      GPIO_EVENT_O <= edge_hit;
    end
  end

  assign GPIO_IRQ_O = |(evt & mask);

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (ADDR_I)
      REG_DIR:    next_rdata[13:0] = dir;
      REG_OUT:    next_rdata[13:0] = out_val;
      REG_IN:     next_rdata[13:0] = gpio_in;
      REG_EVENT:  next_rdata[13:0] = evt;
      REG_MASK:   next_rdata[13:0] = mask;
      REG_STRAP:  next_rdata[13:0] = strap;
      REG_STATUS: begin
        next_rdata[2:0]              = state;
        next_rdata[STAT_ANALOG_BIT]  = ana_seen;
        next_rdata[STAT_TIMEOUT_BIT] = timeout;
        next_rdata[STAT_EXT_BIT]     = boot_opt.ext_supply;
        next_rdata[STAT_SMALL_BIT]   = boot_opt.small_pkg;
      end
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || !RD_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      RDATA_O <= next_rdata;
    end
  end

  sequence s_low3;
    !PIN_RESET_N_I [*3];
  endsequence

  sequence s_release;
    (state == ST_HELD) && PIN_RESET_N_I;
  endsequence

  a_dig_entry_held:
    assert property (s_low3 |=> state == ST_HELD)
      else $error("reset pulse of 3 cycles did not hold the core");

  a_glitch_no_held:
    assert property ((state != ST_HELD) && PIN_RESET_N_I |=>
                     state != ST_HELD)
      else $error("held state entered without a low pin");

  a_analog_cut:
    assert property (!PIN_RESET_N_I && low_cnt == RST_ANA_CYC |=>
                     !CORE_SUPPLY_CONTROL_O && !PLL_ENABLE_O)
      else $error("long reset did not drop supply and pll");

  a_short_keeps_pwr:
    assert property (!PIN_RESET_N_I && low_cnt < RST_ANA_CYC &&
                     CORE_SUPPLY_CONTROL_O |=> CORE_SUPPLY_CONTROL_O)
      else $error("supply dropped on a short reset");

  a_release_pwr_on:
    assert property (s_release |=> CORE_SUPPLY_CONTROL_O && PLL_ENABLE_O
                     && (state == (ana_seen ? ST_PLL_WAIT : ST_SENSE)))
      else $error("release did not restore supply or pick path");

  a_pll_hold_boot:
    assert property ((state == ST_PLL_WAIT) &&
                     (timer < 25'(PLL_WAIT_CYC - 1)) |=>
                     state inside {ST_PLL_WAIT, ST_HELD})
      else $error("boot left pll wait early");

  a_strap_capture:
    assert property (state == ST_SENSE |=>
                     strap == $past(GPIO_I & (PACKAGE_SMALL_I ?
                       PIN_MASK_SMALL : PIN_MASK_LARGE)) ##1
                     state != ST_SENSE)
      else $error("strap levels not captured on sensing");

  a_inputs_in_boot:
    assert property (state != ST_READY |=> GPIO_OE_O == GPIO_RST)
      else $error("pin driven before configuration load");

  a_boot_delay_hold:
    assert property ((state == ST_BOOT_DLY) &&
                     (timer < 25'(BOOT_DLY_CYC - 1)) |=>
                     state != ST_BOOT)
      else $error("boot started before strap delay elapsed");

  a_edge_event_set:
    assert property ((state == ST_READY) && !dir[0] && pin_mask[0] &&
                     (GPIO_I[0] != gpio_in[0]) && !held_now |=>
                     evt[0] && GPIO_EVENT_O[0] ##1 !GPIO_EVENT_O[0] ||
                     (state != ST_READY))
      else $error("input edge did not raise its event");

  a_timeout_auto:
    assert property ($rose(BOOT_TIMEOUT_O) |-> boot_opt.auto_boot &&
                     $past(state) == ST_BOOT)
      else $error("timeout raised outside an auto boot");

endmodule : rbg_ctrl

// ### tb/rbg_pin_model.sv
`timescale 1ns/1ps
module rbg_pin_model
  import rbg_pkg::*;
(
  input  wire logic [13:0] pin_out_i,
  input  wire logic [13:0] pin_oe_i,
  input  wire rbg_gpio_t   pull_up_i,
  output rbg_gpio_t        pin_level_o
);
  // Undriven pins settle at the strap or pull-down level, never float
  assign pin_level_o = (pin_oe_i & pin_out_i)
                     | (~pin_oe_i & pull_up_i);
endmodule : rbg_pin_model

// ### tb/reset_boot_gpio_control_bench.sv
`timescale 1ns/1ps
module reset_boot_gpio_control_bench import rbg_pkg::*;;
  localparam int PLL_CYC = 20;
  localparam int DLY_CYC = 20;
  localparam int LIM_CYC = 200;
  logic          CLOCK_I, RESET_N_I, PIN_RESET_N_I, WR_I, RD_I;
  logic          SUPPLY_SOURCE_SELECT_I, PACKAGE_SMALL_I;
  logic [7:0]    ADDR_I;
  logic [31:0]   WDATA_I, RDATA_O;
  logic [13:0]   GPIO_O, GPIO_OE_O, GPIO_EVENT_O;
  logic          CORE_SUPPLY_CONTROL_O, REGULATOR_INTERNAL_O, PLL_ENABLE_O;
  logic          CORE_RESET_N_O, BOOT_START_O, BOOT_DONE_O, BOOT_TIMEOUT_O;
  logic          GPIO_IRQ_O;
  logic          rd_seen = 1'b0;
  rbg_boot_opt_s BOOT_OPT_O;
  rbg_gpio_t     GPIO_I, pull_up;
  logic [31:0]   exp_q[$];
  int            n_errors, checked;

  rbg_ctrl #(.PLL_WAIT_CYC(PLL_CYC), .BOOT_DLY_CYC(DLY_CYC),
    .BOOT_LIMIT_CYC(LIM_CYC)) u_rbg_ctrl (
    .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
    .PIN_RESET_N_I(PIN_RESET_N_I),
    .SUPPLY_SOURCE_SELECT_I(SUPPLY_SOURCE_SELECT_I),
    .PACKAGE_SMALL_I(PACKAGE_SMALL_I), .GPIO_I(GPIO_I),
    .GPIO_O(GPIO_O), .GPIO_OE_O(GPIO_OE_O), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CORE_SUPPLY_CONTROL_O(CORE_SUPPLY_CONTROL_O),
    .REGULATOR_INTERNAL_O(REGULATOR_INTERNAL_O),
    .PLL_ENABLE_O(PLL_ENABLE_O), .CORE_RESET_N_O(CORE_RESET_N_O),
    .BOOT_START_O(BOOT_START_O), .BOOT_DONE_O(BOOT_DONE_O),
    .BOOT_TIMEOUT_O(BOOT_TIMEOUT_O), .BOOT_OPT_O(BOOT_OPT_O),
    .GPIO_IRQ_O(GPIO_IRQ_O), .GPIO_EVENT_O(GPIO_EVENT_O));

  rbg_pin_model u_rbg_pin_model (.pin_out_i(GPIO_O),
    .pin_oe_i(GPIO_OE_O), .pull_up_i(pull_up), .pin_level_o(GPIO_I));

  initial begin
    CLOCK_I = 1'b0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask : check

  // Read data stand only in the cycle after the strobe
  always @(posedge CLOCK_I) begin
    if (rd_seen) check(RDATA_O, exp_q.pop_front(), "read data");
    rd_seen <= RD_I;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK_I);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    WR_I    <= 1'b1;
    ADDR_I  <= a;
    WDATA_I <= d;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    @(posedge CLOCK_I);
    RD_I   <= 1'b1;
    ADDR_I <= a;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
  endtask : rd

  task automatic pin_low(input int n);
    @(posedge CLOCK_I);
    PIN_RESET_N_I <= 1'b0;
    cyc(n);
  endtask : pin_low

  task automatic pin_high;
    @(posedge CLOCK_I);
    PIN_RESET_N_I <= 1'b1;
  endtask : pin_high

  task automatic boot_start(input int lo);
    int n;
    n = 0;
    while (BOOT_START_O !== 1'b1 && n < 4000) begin
      @(posedge CLOCK_I);
      #1;
      n++;
    end
    check(n >= lo && n <= lo + 6, 1, "boot start delay");
  endtask : boot_start

  task automatic go_ready;
    wr(REG_CTRL, 32'h0000_0001);
    cyc(2);
    check(BOOT_DONE_O, 1, "boot done");
  endtask : go_ready

  // Returns the first event pulse seen within a few cycles
  task automatic evt_wait(output rbg_gpio_t seen, output logic irq);
    seen = 14'h0000;
    irq = 1'b0;
    repeat (4) begin
      @(posedge CLOCK_I);
      #1;
      if (GPIO_EVENT_O !== 14'h0000) begin
        seen = GPIO_EVENT_O;
        irq = GPIO_IRQ_O;
        break;
      end
    end
  endtask : evt_wait

  task automatic toggle(input int p);
    @(posedge CLOCK_I);
    pull_up[p] <= ~pull_up[p];
  endtask : toggle

  initial begin
    #(40 * 20000);
    n_errors++;
    $display("wrong value at %0t ns: run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    rbg_gpio_t seen;
    logic      irq;
    int        p;
    RESET_N_I = 1'b0;
    PIN_RESET_N_I = 1'b1;
    SUPPLY_SOURCE_SELECT_I = 1'b1;
    PACKAGE_SMALL_I = 1'b0;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 8'h00;
    WDATA_I = 32'h0000_0000;
    n_errors = 0;
    checked = 0;
    void'($urandom(52618));
    // Clock runs from time zero, so it is stable before any release
    pull_up = 14'($urandom_range(3, 0));
    p = $urandom_range(10, 3);
    if (p == 5) p = 6;
    cyc(5);
    check(CORE_RESET_N_O, 0, "core held in reset");
    @(posedge CLOCK_I);
    RESET_N_I <= 1'b1;
    cyc(3);
    check(GPIO_OE_O, 14'h0000, "pins are inputs");
    boot_start(DLY_CYC - 3);
    check(BOOT_OPT_O, {3'b010, pull_up[1:0]}, "strap options");
    check(REGULATOR_INTERNAL_O, 0, "external supply");
    check(CORE_SUPPLY_CONTROL_O, 1, "supply enabled");
    go_ready();
    $display("test power-on boot finished");

    wr(REG_MASK, 32'(1 << p));
    toggle(p);
    evt_wait(seen, irq);
    check(seen, 32'(1 << p), "event pulse");
    check(irq, 1, "masked-in interrupt");
    rd(REG_IN, {18'h0_0000, pull_up});
    rd(REG_EVENT, 32'(1 << p));
    wr(REG_EVENT, 32'(1 << p));
    cyc(1);
    check(GPIO_IRQ_O, 0, "interrupt cleared");
    wr(REG_MASK, 32'h0000_0000);
    // Pin 0 is a strap pin, but once running it is an ordinary input
    toggle(0);
    evt_wait(seen, irq);
    check(seen, 32'h0000_0001, "event pulse");
    check(irq, 0, "masked-out interrupt");
    wr(REG_EVENT, 32'h0000_0001);
    $display("test input events finished");

    wr(REG_DIR, 32'h0000_0020);
    wr(REG_OUT, 32'h0000_0020);
    cyc(2);
    check(GPIO_OE_O, 14'h0020, "output enable");
    check(GPIO_O, 14'h0020, "output value");
    rd(REG_DIR, 32'h0000_0020);
    rd(8'h20, 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_0023);
    wr(REG_OUT, 32'h0000_0000);
    evt_wait(seen, irq);
    check(seen, 0, "no event from output pin");
    $display("test directions finished");

    pin_low(1);
    pin_high();
    cyc(4);
    check(BOOT_DONE_O, 1, "short glitch ignored");
    pull_up[1:0] = 2'($urandom_range(3, 0));
    pin_low($urandom_range(240, 3));
    check(CORE_RESET_N_O, 0, "digital reset");
    check(CORE_SUPPLY_CONTROL_O, 1, "supply kept on");
    pin_high();
    boot_start(DLY_CYC - 2);
    check(BOOT_OPT_O, {3'b010, pull_up[1:0]}, "straps resampled");
    rd(REG_DIR, 32'h0000_0000);
    rd(REG_MASK, 32'h0000_0000);
    go_ready();
    $display("test digital reset finished");

    @(posedge CLOCK_I);
    SUPPLY_SOURCE_SELECT_I <= 1'b0;
    pin_low(260);
    check(CORE_SUPPLY_CONTROL_O, 0, "supply dropped");
    check(PLL_ENABLE_O, 0, "clock generator off");
    pin_high();
    cyc(1);
    check(CORE_SUPPLY_CONTROL_O, 1, "supply back at once");
    check(PLL_ENABLE_O, 1, "clock generator back");
    boot_start(PLL_CYC + DLY_CYC - 3);
    check(REGULATOR_INTERNAL_O, 1, "internal regulator");
    go_ready();
    rd(REG_STATUS, 32'h0000_000B);
    $display("test analog reset finished");

    @(posedge CLOCK_I);
    PACKAGE_SMALL_I <= 1'b1;
    pull_up[2] <= 1'b1;
    pin_low(10);
    pin_high();
    boot_start(DLY_CYC - 2);
    cyc(LIM_CYC + 10);
    check(BOOT_TIMEOUT_O, 1, "auto boot timeout");
    check(BOOT_OPT_O, {3'b101, pull_up[1:0]}, "small straps");
    go_ready();
    toggle(12);
    evt_wait(seen, irq);
    check(seen, 0, "no event on absent pin");
    rd(REG_STATUS, 32'h0000_0053);
    wr(REG_DIR, 32'h0000_3FFF);
    wr(REG_OUT, 32'h0000_3FFF);
    cyc(2);
    check(GPIO_O, 14'h07FF, "small package pins");
    $display("test small package finished");
    cyc(3);
    tally_and_finish();
  end
endmodule : reset_boot_gpio_control_bench
